/* File: pkg/sds_pkg.sv */
/*
 * Shared constants and types for the stacked-die serial front end.
 * Assumes a single design clock domain that oversamples the serial pins.
 */
`default_nettype none
package sds_pkg;

   // Instruction codes that every die decodes whatever its role.
   localparam logic [7:0] SDS_OP_DIE_SELECT   = 8'hC2;
   localparam logic [7:0] SDS_OP_DEVICE_RESET = 8'hFF;

   // Bits in one serial byte.
   localparam logic [3:0] SDS_BYTE_BITS = 4'h8;

   // Bits moved per serial clock edge in each lane mode.
   localparam logic [3:0] SDS_STEP_SINGLE = 4'h1;
   localparam logic [3:0] SDS_STEP_DUAL   = 4'h2;
   localparam logic [3:0] SDS_STEP_QUAD   = 4'h4;

   // Lanes driven by the device when it answers in each mode.
   localparam logic [3:0] SDS_MASK_SINGLE = 4'h2;
   localparam logic [3:0] SDS_MASK_DUAL   = 4'h3;
   localparam logic [3:0] SDS_MASK_QUAD   = 4'hF;

   // Lane width of the current instruction, chosen by the command core.
   typedef enum logic [1:0] {
      SDS_LANE_SINGLE,
      SDS_LANE_DUAL,
      SDS_LANE_QUAD
   } sds_lane_t;

   // Framing state of one chip-select frame.
   typedef enum logic [1:0] {
      SDS_FS_OPCODE,
      SDS_FS_STACK_MEMBER_CODE,
      SDS_FS_PASS,
      SDS_FS_IGNORE
   } sds_frame_t;

   // Serial pin levels sampled together.
   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic [3:0] lanes;
   } sds_pins_t;

   // One received byte handed to the command core.
   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } sds_rx_t;

endpackage
`default_nettype wire

/* File: design/sds_front_end.sv */
/*
 * Serial bus front end of a stacked-die serial flash: pin sampling,
 * chip-select framing, lane modes, hold and write-protect roles, and
 * die arbitration by die select and device reset.
 * Assumes the serial clock is far slower than CLK, so that each serial
 * edge is seen by two-flop sampling, and that the command core sets
 * LANES and TX_EN from the opcode it decodes.
 */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Die select opcode plus 8-bit code makes the matching die active.
// - Active and idle dies both decode die select and device reset.
// - Device reset opcode returns every die to its power-up state.
// - After power-up or device reset die zero is active, others idle.
// - At most one die is active and drives the shared lanes.
// - Chip select high keeps every data lane in high impedance.
// - Chip select low lets the device take bytes and return data.
// - Nothing is accepted before the first chip-select falling edge.
// - Single mode input bits are sampled on rising serial clock edges.
// - Single mode output bits change on falling serial clock edges.
// - Dual and quad lanes sample on rising and drive on falling edges.
// - Single and dual modes carry data on lanes zero and one only.
// - Quad mode uses all lanes and disables write-protect and hold.
// - Continuous read streams the whole array from one read command.
// - Read modes differ only in read framing; other commands match.
// - Changing the active die never aborts running program or erase.
// - Serial clock modes 0 and 3 are both accepted.
// - During hold the output is released and input and clock ignored.
module sds_front_end
   import sds_pkg::*;
#(
   parameter int DIES = 2
) (
   input  wire logic            CLK,         // Design clock.
   input  wire logic            RST,         // Asynchronous reset, high.
   input  wire logic            CS_N,        // Chip select pin.
   input  wire logic            SCLK,        // Serial clock pin.
   input  wire logic [3:0]      IO_I,        // Lane pin levels.
   output logic      [3:0]      IO_O,        // Lane drive values.
   output logic      [3:0]      IO_OE,       // Lane drive enables.
   input  wire sds_lane_t       LANES,       // Lane width of instruction.
   input  wire logic            TX_EN,       // Core wants to answer.
   input  wire logic [7:0]      TX_DATA,     // Next answer byte.
   output logic                 TX_LOAD,     // TX_DATA taken this cycle.
   input  wire logic            BUF_MODE,    // Buffered read framing.
   output logic                 CONT_READ,   // Continuous read framing.
   output sds_rx_t              RX,          // Received byte to core.
   output logic                 DEV_RESET,   // Device reset pulse.
   output logic [DIES-1:0]      DIE_ACTIVE,  // One-hot active die, or none.
   output logic                 WP_N,        // Write-protect level.
   output logic                 HOLD_ON      // Pause in effect.
);

   localparam logic [DIES-1:0] DIE_ON_RESET = DIES'(1);

   // Bits moved per serial edge for a lane mode.
   function automatic logic [3:0] lane_step(input sds_lane_t m);
      case (m)
         SDS_LANE_DUAL: lane_step = SDS_STEP_DUAL;
         SDS_LANE_QUAD: lane_step = SDS_STEP_QUAD;
         default:       lane_step = SDS_STEP_SINGLE;
      endcase
   endfunction

   // Lanes that carry an answer in a lane mode.
   function automatic logic [3:0] lane_mask(input sds_lane_t m);
      case (m)
         SDS_LANE_DUAL: lane_mask = SDS_MASK_DUAL;
         SDS_LANE_QUAD: lane_mask = SDS_MASK_QUAD;
         default:       lane_mask = SDS_MASK_SINGLE;
      endcase
   endfunction

   // Places the top bits of a byte on the lanes of a mode.
   function automatic logic [3:0] lane_chunk(input logic [7:0] b,
                                             input sds_lane_t m);
      case (m)
         SDS_LANE_DUAL: lane_chunk = {2'h0, b[7:6]};
         SDS_LANE_QUAD: lane_chunk = b[7:4];
         default:       lane_chunk = {2'h0, b[7], 1'h0};
      endcase
   endfunction

   // Dies whose fixed stack_member_code equals the received code.
   function automatic logic [DIES-1:0] die_match(input logic [7:0] code);
      die_match = '0;
      for (int i = 0; i < DIES; i++) begin
         if (code == 8'(i)) begin
            die_match[i] = 1'b1;
         end
      end
   endfunction

   sds_pins_t        s1_r, s2_r, s3_r;
   logic             cs_act, cs_fall, sclk_rise, sclk_fall, quad;
   logic             hold_r, hold_nxt, armed_r, armed_nxt;
   logic             wp_r, wp_nxt, rx_go, tx_go, rx_done;
   logic [3:0]       step, rx_sum, tx_sum;
   logic [7:0]       rx_sr_r, rx_sr_nxt, tx_sr_r, tx_sr_nxt;
   logic [3:0]       rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
   logic [3:0]       out_r, out_nxt, oe_r, oe_nxt;
   sds_frame_t       fs_r, fs_nxt;
   logic [DIES-1:0]  die_on_r, die_on_nxt;
   sds_rx_t          rx_r, rx_nxt;
   logic             rst_pulse_r, rst_pulse_nxt;

   // Two-flop sampling of the pins; the third stage finds edges.
   // Chip select resets low, so a select held low through reset is not
   // taken for a fresh falling edge; only a real high-to-low arms us.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1_r <= '{cs_n: 1'b0, sclk: 1'b0, lanes: 4'hF};
         s2_r <= '{cs_n: 1'b0, sclk: 1'b0, lanes: 4'hF};
         s3_r <= '{cs_n: 1'b0, sclk: 1'b0, lanes: 4'hF};
      end else begin
         s1_r <= '{cs_n: CS_N, sclk: SCLK, lanes: IO_I};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Edge detection works for either clock idle level at chip select.
   assign cs_act    = !s2_r.cs_n;
   assign cs_fall   = s3_r.cs_n & !s2_r.cs_n;
   assign sclk_rise = s2_r.sclk & !s3_r.sclk;
   assign sclk_fall = !s2_r.sclk & s3_r.sclk;
   assign quad      = (LANES == SDS_LANE_QUAD);
   assign step      = lane_step(LANES);
   assign rx_sum    = rx_cnt_r + step;
   assign tx_sum    = tx_cnt_r + step;

   // Input is taken only when selected, armed and not paused.
   assign rx_go   = cs_act & armed_r & !hold_r & !cs_fall;
   assign rx_done = rx_go & sclk_rise & (rx_sum >= SDS_BYTE_BITS);
   assign tx_go   = rx_go & TX_EN & (|die_on_r);
   assign TX_LOAD = tx_go & sclk_fall & (tx_cnt_r == 4'h0);

   // Pause, arming and write-protect role of lanes two and three.
   always_comb begin
      armed_nxt = armed_r | cs_fall;
      hold_nxt  = hold_r;
      if (!cs_act || quad) begin
         hold_nxt = 1'b0;
      end else if (!s2_r.sclk || sclk_fall) begin
         hold_nxt = !s2_r.lanes[3];
      end
      wp_nxt = quad ? 1'b1 : s2_r.lanes[2];
   end

   // Receive shifter: MSB first, one, two or four bits per rising edge.
   always_comb begin
      rx_sr_nxt  = rx_sr_r;
      rx_cnt_nxt = rx_cnt_r;
      if (!cs_act || cs_fall) begin
         rx_cnt_nxt = 4'h0;
      end else if (rx_go && sclk_rise) begin
         case (LANES)
            SDS_LANE_DUAL: rx_sr_nxt = {rx_sr_r[5:0], s2_r.lanes[1:0]};
            SDS_LANE_QUAD: rx_sr_nxt = {rx_sr_r[3:0], s2_r.lanes};
            default:       rx_sr_nxt = {rx_sr_r[6:0], s2_r.lanes[0]};
         endcase
         rx_cnt_nxt = rx_done ? 4'h0 : rx_sum;
      end
   end

   // Frame decode and die arbitration; only roles change here, so any
   // program or erase running inside a die is left alone.
   always_comb begin
      fs_nxt        = fs_r;
      die_on_nxt    = die_on_r;
      rx_nxt        = '{valid: 1'b0, first: 1'b0, data: rx_r.data};
      rst_pulse_nxt = 1'b0;
      if (!cs_act) begin
         fs_nxt = SDS_FS_OPCODE;
      end else if (rx_done) begin
         case (fs_r)
            SDS_FS_OPCODE: begin
               if (rx_sr_nxt == SDS_OP_DIE_SELECT) begin
                  fs_nxt = SDS_FS_STACK_MEMBER_CODE;
               end else if (rx_sr_nxt == SDS_OP_DEVICE_RESET) begin
                  die_on_nxt    = DIE_ON_RESET;
                  rst_pulse_nxt = 1'b1;
                  fs_nxt        = SDS_FS_IGNORE;
               end else begin
                  fs_nxt = (|die_on_r) ? SDS_FS_PASS : SDS_FS_IGNORE;
                  rx_nxt = '{valid: |die_on_r, first: 1'b1,
                             data: rx_sr_nxt};
               end
            end
            SDS_FS_STACK_MEMBER_CODE: begin
               die_on_nxt = die_match(rx_sr_nxt);
               fs_nxt     = SDS_FS_IGNORE;
            end
            SDS_FS_PASS: begin
               rx_nxt = '{valid: |die_on_r, first: 1'b0, data: rx_sr_nxt};
            end
            default: fs_nxt = SDS_FS_IGNORE;
         endcase
      end
   end

   // Answer shifter: a new chunk goes out on each falling edge.
   always_comb begin
      tx_sr_nxt  = tx_sr_r;
      tx_cnt_nxt = tx_cnt_r;
      out_nxt    = out_r;
      oe_nxt     = tx_go ? lane_mask(LANES) : 4'h0;
      if (!cs_act) begin
         tx_cnt_nxt = 4'h0;
      end else if (tx_go && sclk_fall) begin
         if (tx_cnt_r == 4'h0) begin
            out_nxt   = lane_chunk(TX_DATA, LANES);
            tx_sr_nxt = TX_DATA << step;
         end else begin
            out_nxt   = lane_chunk(tx_sr_r, LANES);
            tx_sr_nxt = tx_sr_r << step;
         end
         tx_cnt_nxt = (tx_sum >= SDS_BYTE_BITS) ? 4'h0 : tx_sum;
      end
   end

   // State registers.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         armed_r     <= 1'b0;
         hold_r      <= 1'b0;
         wp_r        <= 1'b1;
         rx_sr_r     <= 8'h00;
         rx_cnt_r    <= 4'h0;
         fs_r        <= SDS_FS_OPCODE;
         die_on_r    <= DIE_ON_RESET;
         rx_r        <= '0;
         rst_pulse_r <= 1'b0;
         tx_sr_r     <= 8'h00;
         tx_cnt_r    <= 4'h0;
         out_r       <= 4'h0;
         oe_r        <= 4'h0;
      end else begin
         armed_r     <= armed_nxt;
         hold_r      <= hold_nxt;
         wp_r        <= wp_nxt;
         rx_sr_r     <= rx_sr_nxt;
         rx_cnt_r    <= rx_cnt_nxt;
         fs_r        <= fs_nxt;
         die_on_r    <= die_on_nxt;
         rx_r        <= rx_nxt;
         rst_pulse_r <= rst_pulse_nxt;
         tx_sr_r     <= tx_sr_nxt;
         tx_cnt_r    <= tx_cnt_nxt;
         out_r       <= out_nxt;
         oe_r        <= oe_nxt;
      end
   end

   // Outputs; read framing goes to the core as the inverse of BUF_MODE.
   assign IO_O       = out_r;
   assign IO_OE      = oe_r;
   assign RX         = rx_r;
   assign DEV_RESET  = rst_pulse_r;
   assign DIE_ACTIVE = die_on_r;
   assign WP_N       = wp_r;
   assign HOLD_ON    = hold_r;
   assign CONT_READ  = !BUF_MODE;

   // Deselected device leaves every lane undriven.
   property p_cs_highz;
      @(posedge CLK) disable iff (RST) !cs_act |=> (IO_OE == 4'h0);
   endproperty
   a_cs_highz: assert property (p_cs_highz)
      else $error("Lane driven while deselected.");

   // A driven lane implies exactly one active die.
   property p_one_driver;
      @(posedge CLK) disable iff (RST)
         (IO_OE != 4'h0) |-> $onehot($past(die_on_r));
   endproperty
   a_one_driver: assert property (p_one_driver)
      else $error("Lanes driven without a single active die.");

   // Device reset opcode restores die zero as the active die.
   property p_dev_reset;
      @(posedge CLK) disable iff (RST)
         (rx_done && fs_r == SDS_FS_OPCODE &&
          rx_sr_nxt == SDS_OP_DEVICE_RESET)
         |=> (die_on_r == DIE_ON_RESET) && DEV_RESET ##1 !DEV_RESET;
   endproperty
   a_dev_reset: assert property (p_dev_reset)
      else $error("Device reset did not restore die zero.");

   // Reset pulse always shows the power-up die roles.
   property p_reset_roles;
      @(posedge CLK) disable iff (RST) DEV_RESET |-> DIE_ACTIVE == DIE_ON_RESET;
   endproperty
   a_reset_roles: assert property (p_reset_roles)
      else $error("Die roles wrong after device reset.");

   // Code after die select picks the matching die, others go idle.
   property p_die_select;
      @(posedge CLK) disable iff (RST)
         (rx_done && fs_r == SDS_FS_STACK_MEMBER_CODE)
         |=> (die_on_r == die_match($past(rx_sr_nxt)));
   endproperty
   a_die_select: assert property (p_die_select)
      else $error("Die select code not applied.");

   // No byte completes before the first chip-select fall.
   property p_armed;
      @(posedge CLK) disable iff (RST) !armed_r |-> !rx_done && !TX_LOAD;
   endproperty
   a_armed: assert property (p_armed)
      else $error("Activity taken before first select.");

   // Received bytes follow a rising clock edge.
   property p_rx_edge;
      @(posedge CLK) disable iff (RST) RX.valid |-> $past(sclk_rise);
   endproperty
   a_rx_edge: assert property (p_rx_edge)
      else $error("Byte finished off a rising edge.");

   // Answer bytes are loaded on falling edges only.
   property p_tx_edge;
      @(posedge CLK) disable iff (RST) TX_LOAD |-> sclk_fall;
   endproperty
   a_tx_edge: assert property (p_tx_edge)
      else $error("Answer loaded off a falling edge.");

   // Quad mode removes the write-protect and hold roles.
   property p_quad_roles;
      @(posedge CLK) disable iff (RST) quad |=> WP_N && !HOLD_ON;
   endproperty
   a_quad_roles: assert property (p_quad_roles)
      else $error("Pin role active in quad mode.");

   // A pause releases the lanes and blocks input.
   property p_hold;
      @(posedge CLK) disable iff (RST)
         hold_r |-> !rx_done ##1 (IO_OE == 4'h0);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Device active during hold.");

   c_die_select: cover property (@(posedge CLK) disable iff (RST)
      rx_done && fs_r == SDS_FS_STACK_MEMBER_CODE);
   c_dev_reset: cover property (@(posedge CLK) disable iff (RST) DEV_RESET);
   c_quad_out: cover property (@(posedge CLK) disable iff (RST)
      TX_LOAD && quad);
   c_hold: cover property (@(posedge CLK) disable iff (RST) $rose(hold_r));

endmodule
`default_nettype wire

/* File: test/sds_host_model.sv */
/*
 * Host model that drives chip select, serial clock and lanes of the bus.
 * Assumes the bench merges host and device lanes by their enables.
 */
`timescale 1ns/1ns
`default_nettype none
module sds_host_model (
   input  wire logic       clk,     // Bench clock.
   input  wire logic [3:0] io_i,    // Resolved lane levels.
   output logic            cs_n,    // Chip select.
   output logic            sclk,    // Serial clock.
   output logic      [3:0] host_o,  // Host lane values.
   output logic      [3:0] host_oe  // Host lane enables.
);
   bit mode3;

   // Idle bus: deselected, input lane low, write-protect and hold high.
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      host_o = 4'hC;
      host_oe = 4'hD;
   end

   // Waits n cycles and settles a little after the edge.
   task automatic gap(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask

   // Opens a frame with the clock parked at its mode level.
   task automatic start(input bit m3);
      mode3 = m3;
      sclk = m3;
      gap(4);
      cs_n = 1'b0;
      gap(4);
   endtask

   // Sends a byte MSB first, changing data while the clock is low.
   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         host_o[0] = b[i];
         gap(4);
         sclk = 1'b1;
         gap(4);
      end
   endtask

   // Reads n chunks of w bits late in the high phase, because the
   // device output lags each falling edge by its sampling delay.
   task automatic get(input int n, input int w, output logic [7:0] v);
      logic [3:0] c;
      host_oe = (w == 1) ? 4'hD : ((w == 2) ? 4'hC : 4'h0);
      v = 8'h00;
      for (int k = 0; k <= n; k++) begin
         c = io_i & ((w == 2) ? 4'h3 : 4'hF);
         if (w == 1) c = {3'b000, io_i[1]};
         if (k > 0) v = (v << w) | 8'(c);
         sclk = 1'b0;
         gap(4);
         sclk = 1'b1;
         gap(4);
      end
   endtask

   // Closes the frame and gives the lanes back to their idle values.
   task automatic stop();
      if (!mode3) begin
         sclk = 1'b0;
         gap(4);
      end
      cs_n = 1'b1;
      host_o = 4'hC;
      host_oe = 4'hD;
      gap(8);
   endtask

   // Sets the write-protect or hold lane and lets it be sampled.
   task automatic pin(input int i, input logic v);
      host_o[i] = v;
      gap(6);
   endtask
endmodule
`default_nettype wire

/* File: test/sds_front_end_bench.sv */
/*
 * Self-checking bench for the stacked-die serial front end.
 * Assumes the bench plays the command core through LANES and TX lines.
 */
`timescale 1ns/1ns
`default_nettype none
module sds_front_end_bench;
   import sds_pkg::*;
   logic       CLK, RST, TX_EN, BUF_MODE, TX_LOAD, CONT_READ;
   logic       DEV_RESET, WP_N, HOLD_ON, cs_n, sclk, float_r;
   logic [7:0] TX_DATA, v;
   logic [3:0] IO_O, IO_OE, host_o, host_oe, io_res, mask;
   logic [1:0] DIE_ACTIVE;
   sds_lane_t  LANES;
   sds_rx_t    RX;
   logic [8:0] rxq[$], expq[$];
   int         fail_count, checked, resets, exp_die, loads;
   bit         flip;

   // Clock at 100 ns and a lane level that changes when nobody drives.
   always #50 CLK = ~CLK;
   always @(posedge CLK) float_r <= ~float_r;
   assign io_res = (IO_OE & IO_O) | (~IO_OE & host_oe & host_o)
                 | (~IO_OE & ~host_oe & {4{float_r}});

   // Collects received bytes and device reset pulses.
   always @(posedge CLK) begin
      if (RX.valid === 1'b1) rxq.push_back({RX.first, RX.data});
      if (DEV_RESET === 1'b1) resets++;
      if (TX_LOAD === 1'b1) loads++;
   end

   sds_front_end #(
      .DIES       (2)
   ) i_dut (
      .CLK        (CLK),
      .RST        (RST),
      .CS_N       (cs_n),
      .SCLK       (sclk),
      .IO_I       (io_res),
      .IO_O       (IO_O),
      .IO_OE      (IO_OE),
      .LANES      (LANES),
      .TX_EN      (TX_EN),
      .TX_DATA    (TX_DATA),
      .TX_LOAD    (TX_LOAD),
      .BUF_MODE   (BUF_MODE),
      .CONT_READ  (CONT_READ),
      .RX         (RX),
      .DEV_RESET  (DEV_RESET),
      .DIE_ACTIVE (DIE_ACTIVE),
      .WP_N       (WP_N),
      .HOLD_ON    (HOLD_ON)
   );

   sds_host_model i_host (
      .clk        (CLK),
      .io_i       (io_res),
      .cs_n       (cs_n),
      .sclk       (sclk),
      .host_o     (host_o),
      .host_oe    (host_oe)
   );

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input string what, input logic [8:0] exp,
                      input logic [8:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Sends a byte and records it when some die should take it.
   task automatic send(input logic [7:0] b, input bit first);
      i_host.put(b);
      if (exp_die != 0) expq.push_back({first, b});
   endtask

   // Matches expected bytes with seen ones; a missing byte is replaced
   // by its inverse so that it counts as a mismatch.
   task automatic drain();
      while (expq.size() != 0) begin
         if (rxq.size() == 0) rxq.push_back(~expq[0]);
         chk("rx byte", expq.pop_front(), rxq.pop_front());
      end
      chk("rx extra", 9'h000, 9'(rxq.size()));
   endtask

   // Runs a die-select or device-reset frame and checks the active die.
   task automatic die_cmd(input logic [7:0] op, input logic [7:0] code);
      i_host.start(1'b0);
      i_host.put(op);
      if (op == SDS_OP_DIE_SELECT) i_host.put(code);
      i_host.stop();
      rxq.delete();
      exp_die = (code < 2) ? (1 << code) : 0;
      if (op == SDS_OP_DEVICE_RESET) exp_die = 1;
      chk("active die", 9'(exp_die), 9'(DIE_ACTIVE));
   endtask

   // Holds reset for six cycles at the start.
   initial begin
      RST = 1'b1;
      repeat (6) @(posedge CLK);
      #5;
      RST = 1'b0;
   end

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      $display("[FAIL] watchdog expected end seen hang");
      final_report();
   end

   // Main test sequence.
   initial begin
      CLK = 1'b0;
      float_r = 1'b0;
      TX_EN = 1'b0;
      TX_DATA = 8'h00;
      BUF_MODE = 1'b0;
      LANES = SDS_LANE_SINGLE;
      exp_die = 1;
      void'($urandom(32'h8140AAD5));
      // Chip select falls during reset, so the bytes that follow are lost.
      i_host.start(1'b0);
      chk("reset die", 9'h001, 9'(DIE_ACTIVE));
      chk("reset drive", 9'h000, 9'(IO_OE));
      i_host.put(8'h3C);
      i_host.stop();
      chk("early bytes", 9'h000, 9'(rxq.size()));
      $display("test reset done");
      // Random bytes in clock modes 0 and 3.
      for (int m = 0; m < 2; m++) begin
         i_host.start(m[0]);
         send(8'($urandom % 192), 1'b1);
         send(8'($urandom % 192), 1'b0);
         i_host.stop();
         drain();
      end
      $display("test bytes done");
      // Both dies in turn, a stranger code, then device reset.
      die_cmd(SDS_OP_DIE_SELECT, 8'h01);
      die_cmd(SDS_OP_DIE_SELECT, 8'h00);
      die_cmd(SDS_OP_DIE_SELECT, 8'h05);
      i_host.start(1'b0);
      send(8'h0B, 1'b1);
      i_host.stop();
      drain();
      die_cmd(SDS_OP_DEVICE_RESET, 8'h00);
      chk("reset pulses", 9'h001, 9'(resets));
      $display("test dies done");
      // Answers in single, dual and quad lanes after an opcode.
      for (int m = 0; m < 3; m++) begin
         TX_DATA = 8'($urandom);
         mask = (m == 0) ? SDS_MASK_SINGLE
              : ((m == 1) ? SDS_MASK_DUAL : SDS_MASK_QUAD);
         i_host.start(m == 1);
         i_host.put(8'h0B);
         LANES = sds_lane_t'(m);
         TX_EN = 1'b1;
         loads = 0;
         i_host.get(8 >> m, 1 << m, v);
         chk("lane drive", 9'(mask), 9'(IO_OE));
         chk("answer", 9'(TX_DATA), 9'(v));
         // One byte plus one chunk moved: a load at each byte start.
         chk("answer loads", 9'h002, 9'(loads));
         if (m == 2) chk("quad wp", 9'h001, 9'(WP_N));
         i_host.stop();
         TX_EN = 1'b0;
         LANES = SDS_LANE_SINGLE;
         chk("idle drive", 9'h000, 9'(IO_OE));
         rxq.delete();
      end
      $display("test answers done");
      // Write-protect follows lane two; hold pauses input and output.
      i_host.start(1'b0);
      i_host.pin(2, 1'b0);
      chk("wp level", 9'h000, 9'(WP_N));
      i_host.pin(2, 1'b1);
      TX_EN = 1'b1;
      i_host.pin(3, 1'b0);
      chk("hold on", 9'h001, 9'(HOLD_ON));
      chk("hold drive", 9'h000, 9'(IO_OE));
      i_host.put(8'h5A);
      i_host.pin(3, 1'b1);
      i_host.stop();
      TX_EN = 1'b0;
      chk("hold off", 9'h000, 9'(HOLD_ON));
      chk("held bytes", 9'h000, 9'(rxq.size()));
      $display("test hold done");
      // Read framing follows the buffered-mode input.
      flip = 1'($urandom);
      for (int b = 0; b < 2; b++) begin
         BUF_MODE = b[0] ^ flip;
         i_host.gap(1);
         chk("framing", 9'(!BUF_MODE), 9'(CONT_READ));
      end
      $display("test framing done");
      final_report();
   end
endmodule
`default_nettype wire
